// >>> rtl/cpt_pkg.sv
package cpt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int              ADDR_W        = 5;
    localparam logic [4:0]      OFF_CTRL      = 5'h00;
    localparam logic [4:0]      OFF_DUTY      = 5'h04;
    localparam logic [4:0]      OFF_PERIOD    = 5'h08;
    localparam logic [4:0]      OFF_STATUS    = 5'h0C;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int              CTRL_MODE_LSB = 0;
    localparam int              CTRL_RUN_BIT  = 3;
    localparam int              CTRL_CLK_LSB  = 4;
    localparam int              CTRL_INIT_BIT = 7;
    localparam int              STAT_FLOP_BIT = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Field codes
    localparam logic [1:0]      MODE_CODE_PWM  = 2'h0;
    localparam logic [1:0]      MODE_CODE_PPG  = 2'h1;
    localparam logic [1:0]      MODE_CODE_WARM = 2'h2;
    localparam logic [2:0]      CLK_DIV_SLOW   = 3'h0;
    localparam logic [2:0]      CLK_DIV_MID    = 3'h1;
    localparam logic [2:0]      CLK_DIV_FAST   = 3'h2;
    localparam logic [2:0]      CLK_DIV_FASTER = 3'h3;
    localparam logic [2:0]      CLK_SUB        = 3'h4;
    localparam logic [2:0]      CLK_HALF       = 3'h5;
    localparam logic [2:0]      CLK_FULL       = 3'h6;
    localparam logic [2:0]      CLK_EXT        = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler exponents (tick every 2**n core cycles)
    localparam int              PRE_W          = 11;
    localparam int              EXP_SLOW       = 11;
    localparam int              EXP_MID        = 7;
    localparam int              EXP_FAST       = 5;
    localparam int              EXP_FASTER     = 3;
    localparam int              EXP_HALF       = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and limits
    localparam logic [15:0]     DUTY_RST       = 16'h0000;
    localparam logic [15:0]     PERIOD_RST     = 16'hFFFF;
    localparam logic [15:0]     CNT_MAX        = 16'hFFFF;
    localparam logic [2:0]      CLK_SEL_RST    = 3'h0;
    localparam logic [1:0]      RESP_OKAY      = 2'h0;
    localparam logic [1:0]      RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {MODE_PWM, MODE_PPG, MODE_WARM} cpt_mode_t;
    typedef enum logic {RUN_IDLE, RUN_COUNT} cpt_run_t;

endpackage

// >>> rtl/cpt_regs_if.sv
`timescale 1ns/100ps
interface cpt_regs_if;
    logic                          wr_en;
    logic [cpt_pkg::ADDR_W-1:0]    wr_addr;
    logic [31:0]                   wr_data;
    logic [3:0]                    wr_strb;
    logic                          wr_err;
    logic [cpt_pkg::ADDR_W-1:0]    rd_addr;
    logic [31:0]                   rd_data;
    logic                          rd_err;

    modport bus
    (
        output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        input  wr_err, rd_data, rd_err
    );
    modport core
    (
        input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

// >>> rtl/cpt_clk_sel.sv
`timescale 1ns/100ps
module cpt_clk_sel #(
    parameter int FS_EXP = 9
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] sel,
    input  wire logic       ext_pin,
    output logic            tick
);

    typedef struct packed {
        logic [cpt_pkg::PRE_W-1:0] pre;
        logic                      ext_meta;
        logic                      ext_sync;
        logic                      ext_prev;
        logic                      tick;
    } cpt_sel_st_t;

    cpt_sel_st_t q;
    cpt_sel_st_t d;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d          = q;
        d.pre      = q.pre + 1'b1;
        d.ext_meta = ext_pin;
        d.ext_sync = q.ext_meta;
        d.ext_prev = q.ext_sync;
        case (sel)
            cpt_pkg::CLK_DIV_SLOW:   d.tick = &q.pre[cpt_pkg::EXP_SLOW-1:0];
            cpt_pkg::CLK_DIV_MID:    d.tick = &q.pre[cpt_pkg::EXP_MID-1:0];
            cpt_pkg::CLK_DIV_FAST:   d.tick = &q.pre[cpt_pkg::EXP_FAST-1:0];
            cpt_pkg::CLK_DIV_FASTER: d.tick = &q.pre[cpt_pkg::EXP_FASTER-1:0];
            cpt_pkg::CLK_SUB:        d.tick = &q.pre[FS_EXP-1:0];
            cpt_pkg::CLK_HALF:       d.tick = &q.pre[cpt_pkg::EXP_HALF-1:0];
            cpt_pkg::CLK_FULL:       d.tick = 1'b1;
            default:                 d.tick = q.ext_prev & ~q.ext_sync; // Falling edge
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule

// >>> rtl/cpt_axil_slave.sv
`timescale 1ns/100ps
module cpt_axil_slave (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [cpt_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [cpt_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    cpt_regs_if.bus                         regs
);

    typedef struct packed {
        logic [cpt_pkg::ADDR_W-1:0] addr;
        logic                       aw_have;
        logic [31:0]                data;
        logic [3:0]                 strb;
        logic                       w_have;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } cpt_axi_st_t;

    cpt_axi_st_t q;
    cpt_axi_st_t d;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d            = q;
        regs.wr_addr = q.addr;
        regs.wr_data = q.data;
        regs.wr_strb = q.strb;
        regs.wr_en   = q.aw_have && q.w_have && !q.bvalid;
        regs.rd_addr = araddr;
        if (awvalid && q.awready)
        begin
            d.addr    = awaddr;
            d.aw_have = 1'b1;
        end
        if (wvalid && q.wready)
        begin
            d.data   = wdata;
            d.strb   = wstrb;
            d.w_have = 1'b1;
        end
        if (regs.wr_en)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = regs.wr_err ? cpt_pkg::RESP_SLVERR : cpt_pkg::RESP_OKAY;
        end
        else if (q.bvalid && bready)
            d.bvalid = 1'b0;
        if (arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata  = regs.rd_data;
            d.rresp  = regs.rd_err ? cpt_pkg::RESP_SLVERR : cpt_pkg::RESP_OKAY;
        end
        else if (q.rvalid && rready)
            d.rvalid = 1'b0;
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign awready = q.awready;
    assign wready  = q.wready;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign arready = q.arready;
    assign rvalid  = q.rvalid;
    assign rdata   = q.rdata;
    assign rresp   = q.rresp;

endmodule

// >>> rtl/cpt_top.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
module cpt_top #(
    parameter int FS_EXP = 9
)(
    input  wire logic                       CORE_CLK,
    input  wire logic                       SYS_RST,
    input  wire logic [cpt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [31:0]                S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    output logic [1:0]                      S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    input  wire logic [cpt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    output logic [31:0]                     S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    input  wire logic                       EXT_COUNT_PIN,
    output logic                            PWM_OUT_PIN,
    output logic                            PULSE_GEN_OUT_PIN,
    output logic                            CASCADE_MATCH_IRQ
);

    typedef struct packed {
        cpt_pkg::cpt_mode_t mode;
        cpt_pkg::cpt_run_t  run;
        logic [2:0]         clk_sel;
        logic               init_level;
        logic [15:0]        cnt;
        logic [15:0]        duty_buf;
        logic [15:0]        duty_act;
        logic [7:0]         duty_lo_stage;
        logic [15:0]        period;
        logic [7:0]         period_lo_stage;
        logic               flop;
        logic               pwm_pin;
        logic               ppg_pin;
        logic               irq;
    } cpt_core_st_t;

    localparam cpt_core_st_t RST_STATE = '{
        mode:            cpt_pkg::MODE_PWM,
        run:             cpt_pkg::RUN_IDLE,
        clk_sel:         cpt_pkg::CLK_SEL_RST,
        init_level:      1'b0,
        cnt:             16'h0000,
        duty_buf:        cpt_pkg::DUTY_RST,
        duty_act:        cpt_pkg::DUTY_RST,
        duty_lo_stage:   8'h00,
        period:          cpt_pkg::PERIOD_RST,
        period_lo_stage: 8'h00,
        flop:            1'b0,
        pwm_pin:         1'b1,
        ppg_pin:         1'b1,
        irq:             1'b0
    };

    cpt_core_st_t q;
    cpt_core_st_t d;
    logic         tick;
    cpt_regs_if   regs ();

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave and count source

    cpt_axil_slave u_axil (
        .clk     (CORE_CLK),
        .rst     (SYS_RST),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .regs    (regs.bus)
    );

    cpt_clk_sel #(
        .FS_EXP (FS_EXP)
    ) u_clk_sel (
        .clk     (CORE_CLK),
        .rst     (SYS_RST),
        .sel     (q.clk_sel),
        .ext_pin (EXT_COUNT_PIN),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Core logic

    always_comb
    begin
        logic [15:0] cnt_inc;
        logic [15:0] wr_val;
        logic        wr_commit;
        logic        new_run;
        cnt_inc      = q.cnt + 16'h0001;
        wr_val       = 16'h0000;
        wr_commit    = 1'b0;
        new_run      = 1'b0;
        d            = q;
        d.irq        = 1'b0;

        // Read decode
        regs.rd_err  = 1'b0;
        regs.rd_data = 32'h0000_0000;
        if (regs.rd_addr == cpt_pkg::OFF_CTRL)
        begin
            regs.rd_data[cpt_pkg::CTRL_MODE_LSB +: 2] = (q.mode == cpt_pkg::MODE_PPG)  ? cpt_pkg::MODE_CODE_PPG :
                                                        (q.mode == cpt_pkg::MODE_WARM) ? cpt_pkg::MODE_CODE_WARM :
                                                                                         cpt_pkg::MODE_CODE_PWM;
            regs.rd_data[cpt_pkg::CTRL_RUN_BIT]      = (q.run == cpt_pkg::RUN_COUNT);
            regs.rd_data[cpt_pkg::CTRL_CLK_LSB +: 3] = q.clk_sel;
            regs.rd_data[cpt_pkg::CTRL_INIT_BIT]     = q.init_level;
        end
        else if (regs.rd_addr == cpt_pkg::OFF_DUTY)
            regs.rd_data[15:0] = q.duty_act;
        else if (regs.rd_addr == cpt_pkg::OFF_PERIOD)
            regs.rd_data[15:0] = q.period;
        else if (regs.rd_addr == cpt_pkg::OFF_STATUS)
        begin
            regs.rd_data[15:0]                   = q.cnt;
            regs.rd_data[cpt_pkg::STAT_FLOP_BIT] = q.flop;
        end
        else
            regs.rd_err = 1'b1;

        // Write address check
        if (regs.wr_addr == cpt_pkg::OFF_CTRL)
            regs.wr_err = 1'b0;
        else if (regs.wr_addr == cpt_pkg::OFF_DUTY)
            regs.wr_err = 1'b0;
        else if (regs.wr_addr == cpt_pkg::OFF_PERIOD)
            regs.wr_err = 1'b0;
        else if (regs.wr_addr == cpt_pkg::OFF_STATUS)
            regs.wr_err = 1'b0;
        else
            regs.wr_err = 1'b1;

        // Counting
        if (q.run == cpt_pkg::RUN_COUNT && tick)
        begin
            case (q.mode)
                cpt_pkg::MODE_PWM:
                begin
                    if (q.cnt == q.duty_act)
                        d.flop = ~d.flop;
                    if (q.cnt == cpt_pkg::CNT_MAX)
                    begin
                        d.flop     = ~d.flop;
                        d.cnt      = 16'h0000;
                        d.irq      = 1'b1;
                        d.duty_act = q.duty_buf;
                    end
                    else
                        d.cnt = cnt_inc;
                end
                cpt_pkg::MODE_PPG:
                begin
                    if (q.cnt == q.duty_act)
                        d.flop = ~d.flop;
                    if (q.cnt == q.period)
                    begin
                        d.flop = ~d.flop;
                        d.cnt  = 16'h0000;
                        d.irq  = 1'b1;
                    end
                    else
                        d.cnt = cnt_inc;
                end
                default:
                begin
                    if (q.cnt == {q.period[15:8], 8'h00})
                    begin
                        d.cnt = 16'h0000;
                        d.irq = 1'b1;
                    end
                    else
                        d.cnt = cnt_inc;
                end
            endcase
        end

        // Register writes
        if (regs.wr_en && !regs.wr_err)
        begin
            if (regs.wr_addr == cpt_pkg::OFF_CTRL)
            begin
                if (regs.wr_strb[0])
                begin
                    new_run      = regs.wr_data[cpt_pkg::CTRL_RUN_BIT];
                    d.clk_sel    = regs.wr_data[cpt_pkg::CTRL_CLK_LSB +: 3];
                    d.init_level = regs.wr_data[cpt_pkg::CTRL_INIT_BIT];
                    case (regs.wr_data[cpt_pkg::CTRL_MODE_LSB +: 2])
                        cpt_pkg::MODE_CODE_PPG:  d.mode = cpt_pkg::MODE_PPG;
                        cpt_pkg::MODE_CODE_WARM: d.mode = cpt_pkg::MODE_WARM;
                        default:                 d.mode = cpt_pkg::MODE_PWM;
                    endcase
                    if (q.run == cpt_pkg::RUN_IDLE)
                    begin
                        d.flop = regs.wr_data[cpt_pkg::CTRL_INIT_BIT];
                        if (new_run)
                        begin
                            d.run = cpt_pkg::RUN_COUNT;
                            d.cnt = 16'h0000;
                        end
                    end
                    else if (!new_run)
                        d.run = cpt_pkg::RUN_IDLE;
                end
            end
            else if (regs.wr_addr == cpt_pkg::OFF_DUTY)
            begin
                if (regs.wr_strb[0])
                    d.duty_lo_stage = regs.wr_data[7:0];
                if (regs.wr_strb[1])
                begin
                    wr_commit = 1'b1;
                    wr_val    = {regs.wr_data[15:8], d.duty_lo_stage};
                end
                if (wr_commit)
                begin
                    d.duty_buf = wr_val;
                    if (q.run == cpt_pkg::RUN_IDLE || q.mode != cpt_pkg::MODE_PWM)
                        d.duty_act = wr_val;
                end
            end
            else if (regs.wr_addr == cpt_pkg::OFF_PERIOD)
            begin
                if (regs.wr_strb[0])
                    d.period_lo_stage = regs.wr_data[7:0];
                if (regs.wr_strb[1])
                    d.period = {regs.wr_data[15:8], d.period_lo_stage};
            end
        end

        d.pwm_pin = ~d.flop;
        d.ppg_pin = ~d.flop;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
            q <= RST_STATE;
        else
            q <= d;
    end

    // Registered outputs
    assign PWM_OUT_PIN       = q.pwm_pin;
    assign PULSE_GEN_OUT_PIN = q.ppg_pin;
    assign CASCADE_MATCH_IRQ = q.irq;

endmodule

// >>> verification/cpt_props.sv
`timescale 1ns/100ps
module cpt_props (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic PWM_OUT_PIN,
    input wire logic PULSE_GEN_OUT_PIN,
    input wire logic CASCADE_MATCH_IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    property p_pins; PWM_OUT_PIN == PULSE_GEN_OUT_PIN; endproperty
    a_pins: assert property (p_pins) else $error("pins differ");
    property p_rst; $fell(SYS_RST) |-> PWM_OUT_PIN && !CASCADE_MATCH_IRQ; endproperty
    a_rst: assert property (p_rst) else $error("bad reset level");
    property p_irq; CASCADE_MATCH_IRQ |=> !CASCADE_MATCH_IRQ; endproperty
    a_irq: assert property (p_irq) else $error("long irq");
    property p_bblk; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_bblk: assert property (p_bblk) else $error("write ready early");
    property p_rblk; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_rblk: assert property (p_rblk) else $error("read ready early");
    property p_wans;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID;
    endproperty
    a_wans: assert property (p_wans) else $error("write answer late");
    property p_rans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bend; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_bend: assert property (p_bend) else $error("bvalid stuck");
    property p_rend; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_rend: assert property (p_rend) else $error("rvalid stuck");
    ////////////////////////////////////////////////////////////
    c_irq: cover property (CASCADE_MATCH_IRQ);
    c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_fall: cover property ($fell(PWM_OUT_PIN));
endmodule
bind cpt_top cpt_props u_cpt_props (.CORE_CLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
    .S_AXI_RREADY, .PWM_OUT_PIN, .PULSE_GEN_OUT_PIN, .CASCADE_MATCH_IRQ);

// >>> verification/cpt_ext_src.sv
`timescale 1ns/100ps
module cpt_ext_src #(
    parameter int HALF = 4
)(
    input  wire logic clk,
    input  wire logic en,
    output logic      pin
);
    int n = 0;
    initial pin = 1'h1;
    always @(posedge clk)
    begin
        if (!en)
            pin <= 1'h1;
        if (!en || n == HALF - 1)
            n <= 0;
        else
            n <= n + 1;
        if (en && n == HALF - 1)
            pin <= ~pin;
    end
endmodule

// >>> verification/cpt_top_tb.sv
`timescale 1ns/100ps
module cpt_top_tb;
    logic        CORE_CLK = 1'h0;
    logic        SYS_RST = 1'h1;
    logic [4:0]  S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd, rd0;
    logic [3:0]  S_AXI_WSTRB = 4'h0;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, ext_en = 1'h0, p;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic        EXT_COUNT_PIN, PWM_OUT_PIN, PULSE_GEN_OUT_PIN, CASCADE_MATCH_IRQ;
    int          n_fail = 0, checked = 0, gap, flips;

    cpt_top #(.FS_EXP(2)) u_cpt_top (.CORE_CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .EXT_COUNT_PIN, .PWM_OUT_PIN, .PULSE_GEN_OUT_PIN, .CASCADE_MATCH_IRQ);
    cpt_ext_src #(.HALF(4)) u_cpt_ext_src (.clk(CORE_CLK), .en(ext_en), .pin(EXT_COUNT_PIN));

    always #5 CORE_CLK = ~CORE_CLK;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tr, dn;
        int   n;
        n = 0;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_ARADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= w;
        S_AXI_WVALID <= w;
        S_AXI_BREADY <= w;
        S_AXI_ARVALID <= !w;
        S_AXI_RREADY <= !w;
        do
        begin
            @(negedge CORE_CLK);
            ta = S_AXI_AWVALID && S_AXI_AWREADY;
            tw = S_AXI_WVALID && S_AXI_WREADY;
            tr = S_AXI_ARVALID && S_AXI_ARREADY;
            dn = w ? S_AXI_BVALID : S_AXI_RVALID;
            rsp = w ? S_AXI_BRESP : S_AXI_RRESP;
            rd = S_AXI_RDATA;
            @(posedge CORE_CLK);
            if (ta) S_AXI_AWVALID <= 1'h0;
            if (tw) S_AXI_WVALID <= 1'h0;
            if (tr) S_AXI_ARVALID <= 1'h0;
            n++;
        end
        while (dn !== 1'h1 && n < 100);
        S_AXI_BREADY <= 1'h0;
        S_AXI_RREADY <= 1'h0;
        if (n >= 100) n_fail++;
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'h1, a, d, s);
    endtask

    task rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0, 4'h0);
        chk(rd, e);
    endtask

    task meas(input int lim);
        int n;
        n = 0;
        #1;
        while (CASCADE_MATCH_IRQ !== 1'h1 && n < lim)
        begin
            @(posedge CORE_CLK);
            #1 n++;
        end
        gap = 0;
        flips = 0;
        p = PWM_OUT_PIN;
        do
        begin
            @(posedge CORE_CLK);
            #1 gap++;
            if (PWM_OUT_PIN !== p) flips++;
            p = PWM_OUT_PIN;
        end
        while (CASCADE_MATCH_IRQ !== 1'h1 && gap < lim);
    endtask

    task t_reset;
        rdc(5'h00, 32'h0);
        rdc(5'h04, 32'h0);
        rdc(5'h08, 32'hFFFF);
        rdc(5'h0C, 32'h0);
        chk(PWM_OUT_PIN, 1'h1);
        rdc(5'h10, 32'h0);
        chk(rsp, cpt_pkg::RESP_SLVERR);
        wr(5'h14, 32'h1, 4'hF);
        chk(rsp, cpt_pkg::RESP_SLVERR);
    endtask

    task t_ppg;
        wr(5'h04, 32'h5, 4'h3);
        wr(5'h08, 32'h9, 4'h3);
        wr(5'h00, 32'h69, 4'h1);
        meas(50);
        chk(gap, 32'hA);
        chk(flips, 32'h2);
        wr(5'h00, 32'h61, 4'h1);
        p = PULSE_GEN_OUT_PIN;
        rdc(5'h0C, {15'h0, ~p, 16'h0003});
        rd0 = rd;
        repeat (20) @(posedge CORE_CLK);
        chk(PULSE_GEN_OUT_PIN, p);
        rdc(5'h0C, rd0);
        wr(5'h00, 32'h81, 4'h1);
        chk(PULSE_GEN_OUT_PIN, 1'h0);
        wr(5'h00, 32'h01, 4'h1);
        chk(PULSE_GEN_OUT_PIN, 1'h1);
    endtask

    task t_ext;
        wr(5'h04, 32'h1, 4'h3);
        wr(5'h08, 32'h3, 4'h3);
        ext_en <= 1'h1;
        wr(5'h00, 32'h79, 4'h1);
        meas(200);
        chk(gap, 32'h20);
        chk(flips, 32'h2);
        wr(5'h00, 32'h01, 4'h1);
        ext_en <= 1'h0;
        wr(5'h00, 32'h29, 4'h1);
        meas(400);
        chk(gap, 32'h80);
        wr(5'h00, 32'h01, 4'h1);
        wr(5'h00, 32'h39, 4'h1);
        meas(200);
        chk(gap, 32'h20);
        wr(5'h00, 32'h01, 4'h1);
        wr(5'h00, 32'h49, 4'h1);
        meas(200);
        chk(gap, 32'h10);
        wr(5'h00, 32'h01, 4'h1);
        wr(5'h00, 32'h59, 4'h1);
        meas(200);
        chk(gap, 32'h8);
        wr(5'h00, 32'h01, 4'h1);
    endtask

    task t_warm;
        wr(5'h08, 32'h02FF, 4'h3);
        wr(5'h00, 32'h6A, 4'h1);
        meas(2000);
        chk(gap, 32'h201);
        chk(flips, 32'h0);
        wr(5'h00, 32'h02, 4'h1);
    endtask

    task t_pwm;
        int n;
        n = 0;
        wr(5'h00, 32'h60, 4'h1);
        wr(5'h04, 32'h03, 4'h1);
        wr(5'h04, 32'h0100, 4'h2);
        rdc(5'h04, 32'h0103);
        wr(5'h00, 32'h68, 4'h1);
        wr(5'h04, 32'h07, 4'h3);
        rdc(5'h04, 32'h0103);
        while (CASCADE_MATCH_IRQ !== 1'h1 && n < 70000)
        begin
            @(posedge CORE_CLK);
            #1 n++;
        end
        chk(n > 65500 && n < 65540, 1'h1);
        rdc(5'h04, 32'h07);
    endtask

    task give_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        t_reset;
        t_ppg;
        t_ext;
        t_warm;
        t_pwm;
        give_verdict;
    end

    initial
    begin
        repeat (90000) @(posedge CORE_CLK);
        n_fail++;
        give_verdict;
    end
endmodule
